// File: shared/adc_seq_pkg.sv
// shared constants, types and helpers of the conversion sequencer
package adc_seq_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [4:0]  OFS_STATUS    = 5'h00;
  localparam logic [4:0]  OFS_IRQ_EN    = 5'h04;
  localparam logic [4:0]  OFS_TRIGGER   = 5'h08;
  localparam logic [4:0]  OFS_CHANNEL   = 5'h0C;
  localparam logic [4:0]  OFS_RESULT    = 5'h10;
  localparam logic [4:0]  OFS_GENERAL   = 5'h14;
  localparam logic [4:0]  OFS_RESOLUTION = 5'h18;
  localparam logic [31:0] GENERAL_WMASK = 32'h000F_3FFF;
  localparam logic [31:0] RESET_ZERO    = 32'h0000_0000;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_POWERED    = 0;
  localparam int BIT_CONVERTING = 1;
  localparam int BIT_DONE       = 2;
  localparam int BIT_DONE_IE    = 2;
  localparam int BIT_SOFT_TRIG  = 0;
  localparam int BIT_POWER_ON   = 0;
  localparam int BIT_REPEAT     = 1;
  localparam int POS_TRIG_SRC   = 2;
  localparam int BIT_PIN_EDGE   = 4;
  localparam int BIT_SAMPLE_HOLD = 5;
  localparam int POS_CLK_DIV    = 6;
  localparam int POS_GAP        = 8;
  localparam int BIT_REF_SELECT = 12;
  localparam int BIT_REF_INTERNAL = 13;
  localparam int POS_GAIN       = 16;
  localparam int BIT_QUARTER    = 19;
  localparam int POS_RESOLUTION = 30;
  localparam int RESULT_W       = 15;
  localparam logic [1:0] TRIG_SOFT = 2'h0;
  localparam logic [1:0] TRIG_PIN  = 2'h3;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STAB_TIME_NS  = 5000;
  localparam int STAB_CYCLES   = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CONV_CYC_13 = 8'h1D;
  localparam logic [7:0] CONV_CYC_14 = 8'h2D;
  localparam logic [7:0] CONV_CYC_15 = 8'h4D;
  localparam logic [7:0] CONV_CYC_16 = 8'h8D;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_GAP} seq_state_type;
  typedef struct packed {
    logic       powerOn;
    logic       sampling;
    logic       sampleHold;
    logic [3:0] channel;
    logic       channelValid;
    logic [7:0] ampGain;
    logic       quarterScale;
    logic       refExternal;
    logic [1:0] resolution;
  } analog_ctrl_type;

  // conversion clocks per resolution code
  function automatic logic [7:0] conv_cycles(input logic [1:0] res);
    case (res)
      2'h0:    conv_cycles = CONV_CYC_13;
      2'h1:    conv_cycles = CONV_CYC_14;
      2'h2:    conv_cycles = CONV_CYC_15;
      default: conv_cycles = CONV_CYC_16;
    endcase
  endfunction
endpackage

// File: verilog/conv_clock_divider.sv
// conversion clock enable pulse derived from the bus clock
`timescale 1ns/1ps
module conv_clock_divider
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // control
  input  wire logic [1:0] divCode,
  // tick out
  output logic            convTick
);
  logic [2:0] divCount;
  logic [2:0] divMask;

  assign divMask  = 3'(({1'b0, 3'h1} << divCode) - 4'h1);
  assign convTick = ((divCount & divMask) == divMask);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      divCount <= 3'h0;
    else
      divCount <= divCount + 3'h1;
  end

  property p_div_by_eight;
    @(posedge clk_sys) disable iff (rst)
    (divCode == 2'h3) && convTick ##1 (divCode == 2'h3) [*7] |-> !$past(convTick);
  endproperty
  a_div_by_eight: assert property (p_div_by_eight) else $error("divide by 8 ticks too fast");

  property p_div_by_one;
    @(posedge clk_sys) disable iff (rst)
    (divCode == 2'h0) |-> convTick;
  endproperty
  a_div_by_one: assert property (p_div_by_one) else $error("divide by 1 missed a tick");
endmodule // conv_clock_divider

// File: verilog/pin_edge_sync.sv
// two-stage synchroniser and edge detector for the trigger pin
`timescale 1ns/1ps
module pin_edge_sync
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // pin
  input  wire logic pinIn,
  // edges
  output logic      pinRise,
  output logic      pinFall
);
  logic syncFirst;
  logic syncSecond;
  logic pinLast;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      syncFirst  <= 1'b0;
      syncSecond <= 1'b0;
      pinLast    <= 1'b0;
    end
    else
    begin
      syncFirst  <= pinIn;
      syncSecond <= syncFirst;
      pinLast    <= syncSecond;
    end
  end

  assign pinRise = syncSecond & ~pinLast;
  assign pinFall = ~syncSecond & pinLast;

  property p_single_rise;
    @(posedge clk_sys) disable iff (rst)
    pinRise |=> !pinRise;
  endproperty
  a_single_rise: assert property (p_single_rise) else $error("rise pulse lasted two cycles");
endmodule // pin_edge_sync

// File: verilog/adc_conversion_sequencer.sv
// conversion sequencer: registers, power-up, triggers, timing and result
//
// How it works
// - a conversion lasts 29, 45, 77 or 141 conversion clocks for 13..16 bits
// - interrupt follows the done flag only while the done enable bit is set
// - conversion clock is bus clock divided by 1, 2, 4 or 8
// - powered flag rises 5 us after power-on is set
// - converting flag is high exactly while a conversion runs
// - conversions start by software trigger bit or by the trigger pin
// - each conversion end stores the result and sets the done flag
// - done flag clears on writing 0 to it or reading the result
// - single mode: trigger bit starts one, self-clears at end, 0 aborts
// - continuous mode: conversions repeat while the trigger bit stays 1
// - gap between repeated conversions: none, or 2^(n-1) conversion clocks
// - triggers pass a two-stage resync before starting a conversion
// - channel code routes temp sensor, eight pins, amplifier or supply
// - quarter scale bit scales the input by one quarter
// - amplifier gain is two to the power of the gain code
// - reference select bit picks external (1) or internal (0) reference
// - result occupies bits 14:0, upper bits read zero
// - trigger source 00 software, 11 pin, others reserved
// - repeat mode bit: 0 single, 1 continuous
// - pin edge bit picks start edge; opposite edge ends continuous runs
// - resolution code 00..11 gives 13..16 bits
`timescale 1ns/1ps
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // avalon-mm slave
  input  wire logic [4:0]          avsAddress,
  input  wire logic                avsRead,
  input  wire logic                avsWrite,
  input  wire logic [3:0]          avsByteEnable,
  input  wire logic [31:0]         avsWriteData,
  output logic [31:0]              avsReadData,
  output logic                     avsWaitRequest,
  // external trigger pin
  input  wire logic                trigPin,
  // analog core
  input  wire logic [RESULT_W-1:0] analogResult,
  output analog_ctrl_type          analogCtrl,
  output logic                     convTick,
  // interrupt toward the core-local controller
  output logic                     doneIrq
);
  // ----------------------------------------------------------------
  // bus slave: one wait cycle, then the access completes
  // ----------------------------------------------------------------
  logic        busAck;
  logic        busAccept;
  logic        wrAccept;
  logic        rdAccept;
  logic [31:0] byteMask;

  assign avsWaitRequest = (avsRead | avsWrite) & ~busAck;
  assign busAccept      = (avsRead | avsWrite) & busAck;
  assign wrAccept       = busAccept & avsWrite;
  assign rdAccept       = busAccept & avsRead;

  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_mask
      assign byteMask[8*b +: 8] = {8{avsByteEnable[b]}};
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      busAck <= 1'b0;
    else
      busAck <= (avsRead | avsWrite) & ~busAck;
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [31:0]         generalCfg;
  logic [3:0]          channelSel;
  logic                doneIrqEnable;
  logic [1:0]          resolutionSel;
  logic                softTrigger;
  logic                doneFlag;
  logic                powered;
  logic [RESULT_W-1:0] result;
  logic                convEnd;
  seq_state_type       state;

  wire logic       powerOn   = generalCfg[BIT_POWER_ON];
  wire logic       repeatOn  = generalCfg[BIT_REPEAT];
  wire logic [1:0] trigSrc   = generalCfg[POS_TRIG_SRC +: 2];
  wire logic       pinEdge   = generalCfg[BIT_PIN_EDGE];
  wire logic [3:0] gapCode   = generalCfg[POS_GAP +: 4];
  wire logic       swSel     = (trigSrc == TRIG_SOFT);
  wire logic       pinSel    = (trigSrc == TRIG_PIN);
  wire logic       wrGeneral = wrAccept && (avsAddress == OFS_GENERAL);
  wire logic       wrTrigger = wrAccept && (avsAddress == OFS_TRIGGER) && avsByteEnable[0];
  wire logic       wrStatus  = wrAccept && (avsAddress == OFS_STATUS) && avsByteEnable[0];
  wire logic       rdResult  = rdAccept && (avsAddress == OFS_RESULT);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      generalCfg    <= RESET_ZERO;
      channelSel    <= 4'h0;
      doneIrqEnable <= 1'b0;
      resolutionSel <= 2'h0;
    end
    else if (wrAccept)
    begin
      case (avsAddress)
        OFS_GENERAL:
          generalCfg <= (generalCfg & ~(byteMask & GENERAL_WMASK))
                        | (avsWriteData & byteMask & GENERAL_WMASK);
        OFS_CHANNEL:
          if (avsByteEnable[0])
            channelSel <= avsWriteData[3:0];
        OFS_IRQ_EN:
          if (avsByteEnable[0])
            doneIrqEnable <= avsWriteData[BIT_DONE_IE];
        OFS_RESOLUTION:
          if (avsByteEnable[3])
            resolutionSel <= avsWriteData[POS_RESOLUTION +: 2];
        default:
          ;
      endcase
    end
  end

  // software trigger: a software write of 1 wins over the hardware clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      softTrigger <= 1'b0;
    else if (wrTrigger)
      softTrigger <= avsWriteData[BIT_SOFT_TRIG];
    else if (convEnd && !repeatOn && swSel)
      softTrigger <= 1'b0;
  end

  // done flag: set wins over both clears
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      doneFlag <= 1'b0;
    else if (convEnd)
      doneFlag <= 1'b1;
    else if (rdResult || (wrStatus && !avsWriteData[BIT_DONE]))
      doneFlag <= 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      result <= '0;
    else if (convEnd)
      result <= analogResult;
  end

  assign doneIrq = doneFlag & doneIrqEnable;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      avsReadData <= RESET_ZERO;
    else if (avsRead && !busAck)
    begin
      case (avsAddress)
        OFS_STATUS:     avsReadData <= {29'h0, doneFlag, (state == ST_CONVERT), powered};
        OFS_IRQ_EN:     avsReadData <= {29'h0, doneIrqEnable, 2'h0};
        OFS_TRIGGER:    avsReadData <= {31'h0, softTrigger};
        OFS_CHANNEL:    avsReadData <= {28'h0, channelSel};
        OFS_RESULT:     avsReadData <= {17'h0, result};
        OFS_GENERAL:    avsReadData <= generalCfg;
        OFS_RESOLUTION: avsReadData <= {resolutionSel, 30'h0};
        default:        avsReadData <= RESET_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // power-up stabilisation
  // ----------------------------------------------------------------
  logic [9:0] stabCount;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stabCount <= 10'h000;
      powered   <= 1'b0;
    end
    else if (!powerOn)
    begin
      stabCount <= 10'h000;
      powered   <= 1'b0;
    end
    else if (stabCount == 10'(STAB_CYCLES - 1))
      powered   <= 1'b1;
    else
      stabCount <= stabCount + 10'h001;
  end

  // ----------------------------------------------------------------
  // trigger sources
  // ----------------------------------------------------------------
  logic pinRise;
  logic pinFall;
  logic softSyncA;
  logic softSync;
  logic pinPending;
  logic pinRun;

  pin_edge_sync u_pin_edge_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pinIn   (trigPin),
    .pinRise (pinRise),
    .pinFall (pinFall)
  );

  wire logic pinStart = pinEdge ? pinFall : pinRise;
  wire logic pinStop  = pinEdge ? pinRise : pinFall;

  // the trigger bit reaches the sequencer two clocks late
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      softSyncA <= 1'b0;
      softSync  <= 1'b0;
    end
    else
    begin
      softSyncA <= softTrigger;
      softSync  <= softSyncA;
    end
  end

  // a pin edge during power-up is held until the converter is powered
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pinPending <= 1'b0;
      pinRun     <= 1'b0;
    end
    else
    begin
      if (!pinSel || repeatOn || !powerOn)
        pinPending <= 1'b0;
      else if (pinStart)
        pinPending <= 1'b1;
      else if (state == ST_IDLE && convTick && powered)
        pinPending <= 1'b0;
      if (!pinSel || !repeatOn || pinStop)
        pinRun <= 1'b0;
      else if (pinStart)
        pinRun <= 1'b1;
    end
  end

  wire logic want = swSel  ? (softTrigger & softSync)
                  : pinSel ? (repeatOn ? pinRun : pinPending)
                  : 1'b0;

  // ----------------------------------------------------------------
  // conversion sequence
  // ----------------------------------------------------------------
  logic [7:0]  convCount;
  logic [14:0] gapCount;
  logic [7:0]  convTarget;
  logic [14:0] gapTarget;

  conv_clock_divider u_conv_clock_divider (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .divCode  (generalCfg[POS_CLK_DIV +: 2]),
    .convTick (convTick)
  );

  assign convTarget = conv_cycles(resolutionSel);
  assign gapTarget  = 15'h0001 << (gapCode - 4'h1);
  assign convEnd    = (state == ST_CONVERT) && convTick
                      && (convCount == convTarget - 8'h01);
  // a pin-started single conversion runs to its end once its edge is consumed
  wire logic holdRun  = swSel  ? softTrigger
                      : pinSel ? (repeatOn ? pinRun : 1'b1)
                      : 1'b0;
  wire logic abortRun = !powered || !holdRun;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state     <= ST_IDLE;
      convCount <= 8'h00;
      gapCount  <= 15'h0000;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (powered && want && convTick)
          begin
            state     <= ST_CONVERT;
            convCount <= 8'h00;
          end
        ST_CONVERT:
          if (abortRun && !convEnd)
            state <= ST_IDLE;
          else if (convEnd)
          begin
            convCount <= 8'h00;
            gapCount  <= 15'h0000;
            if (!repeatOn || abortRun)
              state <= ST_IDLE;
            else if (gapCode != 4'h0)
              state <= ST_GAP;
          end
          else if (convTick)
            convCount <= convCount + 8'h01;
        ST_GAP:
          if (abortRun)
            state <= ST_IDLE;
          else if (convTick)
          begin
            if (gapCount == gapTarget - 15'h0001)
              state <= ST_CONVERT;
            gapCount <= gapCount + 15'h0001;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // analog control outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    analogCtrl.powerOn      = powerOn;
    analogCtrl.sampling     = (state == ST_CONVERT);
    analogCtrl.sampleHold   = generalCfg[BIT_SAMPLE_HOLD];
    analogCtrl.channel      = channelSel;
    analogCtrl.channelValid = (channelSel != 4'h1) && (channelSel <= 4'hB);
    analogCtrl.ampGain      = 8'h01 << generalCfg[POS_GAIN +: 3];
    analogCtrl.quarterScale = generalCfg[BIT_QUARTER];
    analogCtrl.refExternal  = generalCfg[BIT_REF_SELECT];
    analogCtrl.resolution   = resolutionSel;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_irq_follows_done;
    @(posedge clk_sys) disable iff (rst)
    convEnd && doneIrqEnable |=> doneIrq;
  endproperty
  a_irq_follows_done: assert property (p_irq_follows_done) else $error("irq missing");

  property p_no_early_start;
    @(posedge clk_sys) disable iff (rst)
    $rose(analogCtrl.sampling) |-> $past(powered);
  endproperty
  a_no_early_start: assert property (p_no_early_start) else $error("started unpowered");

  property p_result_stored;
    @(posedge clk_sys) disable iff (rst)
    convEnd |=> doneFlag && (result == $past(analogResult));
  endproperty
  a_result_stored: assert property (p_result_stored) else $error("result not stored");

  property p_read_clears;
    @(posedge clk_sys) disable iff (rst)
    rdResult && !convEnd |=> !doneFlag && !doneIrq;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear");

  property p_single_self_clear;
    @(posedge clk_sys) disable iff (rst)
    convEnd && !repeatOn && swSel && !wrTrigger |=> !softTrigger ##1 (state == ST_IDLE);
  endproperty
  a_single_self_clear: assert property (p_single_self_clear) else $error("no self clear");

  property p_gap_entry;
    @(posedge clk_sys) disable iff (rst)
    convEnd && repeatOn && !abortRun |=> (state == (gapCode == 4'h0 ? ST_CONVERT : ST_GAP));
  endproperty
  a_gap_entry: assert property (p_gap_entry) else $error("wrong gap entry");

  property p_powered_delay;
    @(posedge clk_sys) disable iff (rst)
    $rose(powered) |-> $past(powerOn, 10) && (stabCount == 10'(STAB_CYCLES - 1));
  endproperty
  a_powered_delay: assert property (p_powered_delay) else $error("powered too early");

  property p_conv_length;
    @(posedge clk_sys) disable iff (rst)
    convEnd |-> (convCount + 8'h01) == ((resolutionSel == 2'h0) ? CONV_CYC_13
                                       : (resolutionSel == 2'h1) ? CONV_CYC_14
                                       : (resolutionSel == 2'h2) ? CONV_CYC_15 : CONV_CYC_16);
  endproperty
  a_conv_length: assert property (p_conv_length) else $error("conversion length wrong");

  property p_soft_resync;
    @(posedge clk_sys) disable iff (rst)
    $rose(analogCtrl.sampling) && swSel |-> $past(softTrigger, 2);
  endproperty
  a_soft_resync: assert property (p_soft_resync) else $error("start before resync");
endmodule // adc_conversion_sequencer

// File: dv/adc_far_side.sv
// far-side model: analog core result and trigger pin
`timescale 1ns/1ps
module adc_far_side
  import adc_seq_pkg::*;
(
  // from the sequencer and bench
  input  wire analog_ctrl_type     analogCtrl,
  input  wire logic                pinLevel,
  // toward the sequencer
  output logic [RESULT_W-1:0]      analogResult,
  output logic                     trigPin
);
  logic [RESULT_W-1:0] sample;

  // result follows the routed channel; inverted outside a conversion so a stale grab shows
  assign sample       = {analogCtrl.channel, 11'h2A5};
  assign analogResult = analogCtrl.sampling ? sample : ~sample;
  assign trigPin      = pinLevel;
endmodule // adc_far_side

// File: dv/testbench.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module testbench
  import adc_seq_pkg::*;
;
  logic                clk_sys = 1'b0;
  logic                rst = 1'b1;
  logic [4:0]          avsAddress = 5'h00;
  logic                avsRead = 1'b0;
  logic                avsWrite = 1'b0;
  logic [31:0]         avsWriteData = 32'h0;
  logic [31:0]         avsReadData;
  logic                avsWaitRequest;
  logic                trigPin;
  logic                pinLevel = 1'b0;
  logic                convTick;
  logic                doneIrq;
  logic [RESULT_W-1:0] analogResult;
  analog_ctrl_type     analogCtrl;
  logic [31:0]         rd;
  int                  error_cnt = 0;
  int                  check_count = 0;
  int                  tickCnt = 0;
  int                  cycCnt = 0;
  int                  lastTicks = 0;
  int                  lastGap = 0;
  int                  gapCnt = 0;
  logic                samplingLast = 1'b0;
  longint              t0;

  adc_conversion_sequencer uut (.clk_sys(clk_sys), .rst(rst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsByteEnable(4'hF),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .trigPin(trigPin), .analogResult(analogResult), .analogCtrl(analogCtrl),
    .convTick(convTick), .doneIrq(doneIrq));
  adc_far_side far (.analogCtrl(analogCtrl), .pinLevel(pinLevel),
    .analogResult(analogResult), .trigPin(trigPin));

  always #5 clk_sys = ~clk_sys;

  // conversion length seen at the ports, in bus clocks and in conversion ticks,
  // and the idle bus clocks before the latest conversion
  always @(posedge clk_sys)
  begin
    samplingLast <= analogCtrl.sampling;
    if (analogCtrl.sampling === 1'b1)
    begin
      cycCnt  <= (samplingLast === 1'b1) ? cycCnt + 1 : 1;
      tickCnt <= ((samplingLast === 1'b1) ? tickCnt : 0) + int'(convTick === 1'b1);
      if (samplingLast !== 1'b1)
        lastGap <= gapCnt;
    end
    else
    begin
      gapCnt <= (samplingLast === 1'b1) ? 1 : gapCnt + 1;
      if (samplingLast === 1'b1)
        lastTicks <= tickCnt;
    end
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon access; holds everything until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avsAddress   <= a;
    avsWriteData <= d;
    avsWrite     <= wr;
    avsRead      <= ~wr;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avsWaitRequest !== 1'b0 && n < 20);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
    if (n == 20)
    begin
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic waitStatus(input int b);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    while (rd[b] !== 1'b1 && n < 1000);
    if (n == 1000)
    begin
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic t_reset;
    rdchk(OFS_STATUS, RESET_ZERO);
    rdchk(OFS_TRIGGER, RESET_ZERO);
    rdchk(OFS_RESULT, RESET_ZERO);
    bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
    rdchk(5'h1C, RESET_ZERO);
    $display("t_reset done");
  endtask

  task automatic t_power;
    // divider set while still off, sample-hold on
    bus(1'b1, OFS_GENERAL, 32'h0000_00A0);
    bus(1'b1, OFS_GENERAL, 32'h0000_00A1);
    t0 = $time;
    rdchk(OFS_STATUS, 32'h0);
    waitStatus(0);
    chk(32'(($time - t0) >= (STAB_CYCLES - 3) * CLK_PERIOD_NS), 32'h1);
    chk(32'(($time - t0) <= (STAB_CYCLES + 9) * CLK_PERIOD_NS), 32'h1);
    $display("t_power done");
  endtask

  task automatic t_soft;
    bus(1'b1, OFS_IRQ_EN, 32'h4);
    bus(1'b1, OFS_CHANNEL, 32'h3);
    bus(1'b1, OFS_TRIGGER, 32'h1);
    waitStatus(1);
    chk(rd, 32'h3);
    waitStatus(2);
    chk(rd, 32'h5);
    chk(tickCnt, 32'd29);
    chk(32'(cycCnt >= 29 * 4 - 4 && cycCnt <= 29 * 4 + 4), 32'h1);
    chk({31'h0, doneIrq}, 32'h1);
    rdchk(OFS_TRIGGER, 32'h0);
    rdchk(OFS_RESULT, {17'h0, 4'h3, 11'h2A5});
    rdchk(OFS_STATUS, 32'h1);
    chk({31'h0, doneIrq}, 32'h0);
    $display("t_soft done");
  endtask

  task automatic t_pin;
    bus(1'b1, OFS_IRQ_EN, 32'h0);
    // reserved source code must never start a conversion
    bus(1'b1, OFS_GENERAL, 32'h0000_00A5);
    bus(1'b1, OFS_TRIGGER, 32'h1);
    repeat (400) @(posedge clk_sys);
    rdchk(OFS_STATUS, 32'h1);
    bus(1'b1, OFS_TRIGGER, 32'h0);
    bus(1'b1, OFS_GENERAL, 32'h0000_00AD);
    pinLevel <= 1'b1;
    waitStatus(2);
    chk(rd, 32'h5);
    chk({31'h0, doneIrq}, 32'h0);
    bus(1'b1, OFS_STATUS, 32'h0);
    rdchk(OFS_STATUS, 32'h1);
    pinLevel <= 1'b0;
    $display("t_pin done");
  endtask

  task automatic t_cont;
    // power off before the divider moves to 8; then continuous, gap code 2, 14 bits
    bus(1'b1, OFS_GENERAL, 32'h0000_00A0);
    bus(1'b1, OFS_GENERAL, 32'h000B_12E2);
    bus(1'b1, OFS_RESOLUTION, 32'h4000_0000);
    bus(1'b1, OFS_CHANNEL, 32'h1);
    @(posedge clk_sys);
    chk({31'h0, analogCtrl.channelValid}, 32'h0);
    bus(1'b1, OFS_CHANNEL, 32'hB);
    bus(1'b1, OFS_GENERAL, 32'h000B_12E3);
    @(posedge clk_sys);
    chk({24'h0, analogCtrl.ampGain}, 32'h8);
    chk({30'h0, analogCtrl.quarterScale, analogCtrl.refExternal}, 32'h3);
    chk({30'h0, analogCtrl.resolution}, 32'h1);
    waitStatus(0);
    bus(1'b1, OFS_IRQ_EN, 32'h4);
    bus(1'b1, OFS_TRIGGER, 32'h1);
    waitStatus(2);
    rdchk(OFS_RESULT, {17'h0, 4'hB, 11'h2A5});
    waitStatus(2);
    chk({31'h0, doneIrq}, 32'h1);
    chk(lastTicks, 32'd45);
    // two conversion clocks of eight bus clocks each
    chk(lastGap, 32'd16);
    bus(1'b1, OFS_TRIGGER, 32'h0);
    repeat (60) @(posedge clk_sys);
    rdchk(OFS_STATUS, 32'h5);
    $display("t_cont done");
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_power();
    t_soft();
    t_pin();
    t_cont();
    finish_test();
  end
endmodule // testbench
